// ===== logic/ptc_pkg.sv
// Constants and types of the prescaled timer/counter
//**********************************************************************
// Function
//**********************************************************************
package ptc_pkg;
    typedef logic [7:0] ptc_count_t;
    typedef logic [2:0] ptc_ratio_t;
    typedef logic [7:0] ptc_scale_t;
    typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} ptc_phase_t;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TOSC_NS = 10;
    localparam int CLKS_PER_TOSC = (TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TOSC_PER_INSTR = 4;
    localparam int WR_HOLD_INSTR = 2;
    localparam int ROLL_DELAY_TOSC = 3;
    localparam logic [3:0] WR_HOLD_CLKS = 4'(WR_HOLD_INSTR * TOSC_PER_INSTR * CLKS_PER_TOSC);
    localparam logic [1:0] ROLL_DELAY_CLKS = 2'(ROLL_DELAY_TOSC * CLKS_PER_TOSC);
    localparam ptc_count_t COUNT_RESET = 8'h00;
    localparam ptc_count_t COUNT_MAX = 8'hFF;
    localparam ptc_scale_t SCALE_RESET = 8'h00;
endpackage

// ===== logic/ptc_if.sv
// Link between the timer core and the shared prescaler
`timescale 1ns/10ps
interface ptc_if;
    logic src_level;
    logic clear;
    logic run;
    ptc_pkg::ptc_ratio_t ratio;
    logic out_level;
    modport core
    (
        output src_level,
        output clear,
        output run,
        output ratio,
        input out_level
    );
    modport scaler
    (
        input src_level,
        input clear,
        input run,
        input ratio,
        output out_level
    );
endinterface

// ===== logic/ptc_prescaler.sv
// Shared eight-bit prescaler with selectable tap
`timescale 1ns/10ps
module ptc_prescaler
(
    input wire logic clk,
    input wire logic nrst,
    ptc_if.scaler ps
);
    import ptc_pkg::*;

    logic src_prev_reg;
    ptc_scale_t scale_reg;
    logic out_reg;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            src_prev_reg <= 1'b0;
        else
            src_prev_reg <= ps.src_level;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            scale_reg <= SCALE_RESET;
        else if (ps.clear)
            scale_reg <= SCALE_RESET;
        else if (ps.run && ps.src_level && !src_prev_reg)
            scale_reg <= scale_reg + 8'h01;
    end

    // Tap n toggles every 2^n edges: divide 2^(n+1)
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            out_reg <= 1'b0;
        else
            out_reg <= scale_reg[ps.ratio];
    end

    assign ps.out_level = out_reg;
endmodule

// ===== logic/ptc_timer.sv
// Eight-bit timer/counter with shared prescaler and overflow flag
`timescale 1ns/10ps
module ptc_timer
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic sleep,
    input wire logic clock_source_select,
    input wire logic count_edge_select,
    input wire logic prescaler_assign,
    input wire ptc_pkg::ptc_ratio_t prescale_ratio_field,
    input wire logic external_count_pin,
    input wire logic count_wr,
    input wire ptc_pkg::ptc_count_t count_wdata,
    input wire logic timer_overflow_enable,
    input wire logic flag_clear,
    input wire logic watchdog_clear_instruction,
    input wire logic watchdog_tick,
    output logic [7:0] count_register,
    output logic timer_overflow_flag,
    output logic timer_irq,
    output logic instr_cycle_strobe,
    output logic watchdog_scaled_tick
);
    import ptc_pkg::*;

    //******************************************************************
    // Declarations
    //******************************************************************
    ptc_phase_t phase_reg;
    ptc_phase_t phase_next;
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic instr_clk_reg;
    logic timer_src;
    logic pre_out;
    logic sample_reg;
    logic sample_prev_reg;
    logic inc_pulse_reg;
    logic [3:0] hold_cnt_reg;
    logic [1:0] roll_cnt_reg;
    ptc_count_t count_reg;
    logic flag_reg;
    logic irq_reg;
    logic strobe_reg;
    logic wdog_tick_reg;
    logic overflow_inc;
    logic count_inc;
    logic sample_phase;

    ptc_if ps_link ();

    //******************************************************************
    // Instruction phase sequencer
    //******************************************************************
    always_comb
    begin
        case (phase_reg)
            PH_ONE: phase_next = PH_TWO;
            PH_TWO: phase_next = PH_THREE;
            PH_THREE: phase_next = PH_FOUR;
            PH_FOUR: phase_next = PH_ONE;
            default: phase_next = PH_ONE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            phase_reg <= PH_ONE;
        else if (!sleep)
            phase_reg <= phase_next;
    end

    // Instruction clock high in phases three and four
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            instr_clk_reg <= 1'b0;
        else if (!sleep)
            instr_clk_reg <= (phase_next == PH_THREE) || (phase_next == PH_FOUR);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            strobe_reg <= 1'b0;
        else
            strobe_reg <= !sleep && (phase_reg == PH_FOUR);
    end

    //******************************************************************
    // External pin synchroniser
    //******************************************************************
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end
        else
        begin
            pin_meta_reg <= external_count_pin;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    //******************************************************************
    // Count source and shared prescaler
    //******************************************************************
    always_comb
    begin
        timer_src = instr_clk_reg;
        if (clock_source_select)
        begin
            timer_src = pin_sync_reg ^ count_edge_select;
        end
    end

    // switch takes effect on the next edge
    assign ps_link.src_level = prescaler_assign ? watchdog_tick : timer_src;
    assign ps_link.run = prescaler_assign || !sleep;
    assign ps_link.ratio = prescale_ratio_field;

    assign ps_link.clear = prescaler_assign ? watchdog_clear_instruction : count_wr;

    // divide by 2^(n+1) inside the prescaler
    ptc_prescaler u_prescaler
    (
        .clk(clk),
        .nrst(nrst),
        .ps(ps_link.scaler)
    );

    assign pre_out = prescaler_assign ? timer_src : ps_link.out_level;

    // Watchdog gets undivided tick when not assigned
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            wdog_tick_reg <= 1'b0;
        else
            wdog_tick_reg <= prescaler_assign ? ps_link.out_level : watchdog_tick;
    end

    //******************************************************************
    // Phase sampler and increment pulse
    //******************************************************************
    assign sample_phase = (phase_reg == PH_TWO) || (phase_reg == PH_FOUR);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            sample_reg <= 1'b0;
        else if (!sleep && sample_phase)
            sample_reg <= pre_out;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            sample_prev_reg <= 1'b0;
        else
            sample_prev_reg <= sample_reg;
    end

    // pin change to increment in a few periods
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            inc_pulse_reg <= 1'b0;
        else
            inc_pulse_reg <= !sleep && sample_reg && !sample_prev_reg;
    end

    //******************************************************************
    // Counter register
    //******************************************************************
    // increments dropped while hold runs
    assign count_inc = inc_pulse_reg && (hold_cnt_reg == 4'h0) && !count_wr;
    assign overflow_inc = count_inc && (count_reg == COUNT_MAX) && (roll_cnt_reg == 2'h0);

    // two instruction cycles after a write
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            hold_cnt_reg <= 4'h0;
        else if (count_wr)
            hold_cnt_reg <= WR_HOLD_CLKS;
        else if (hold_cnt_reg != 4'h0)
            hold_cnt_reg <= hold_cnt_reg - 4'h1;
    end

    // zero shows three periods after the pulse
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            roll_cnt_reg <= 2'h0;
        else if (count_wr)
            roll_cnt_reg <= 2'h0;
        else if (overflow_inc)
            roll_cnt_reg <= ROLL_DELAY_CLKS;
        else if (roll_cnt_reg != 2'h0)
            roll_cnt_reg <= roll_cnt_reg - 2'h1;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            count_reg <= COUNT_RESET;
        else if (count_wr)
            count_reg <= count_wdata;
        else if (roll_cnt_reg == 2'h1)
            count_reg <= COUNT_RESET;
        else if (count_inc && (count_reg != COUNT_MAX))
            count_reg <= count_reg + 8'h01;
    end

    //******************************************************************
    // Overflow flag and request
    //******************************************************************
    // increment at FF sets the flag, three periods ahead of the wrap
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            flag_reg <= 1'b0;
        else if (overflow_inc)
            flag_reg <= 1'b1;
        else if (flag_clear)
            flag_reg <= 1'b0;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            irq_reg <= 1'b0;
        else
            irq_reg <= flag_reg && timer_overflow_enable;
    end

    //******************************************************************
    // Outputs
    //******************************************************************
    // count visible to reads
    assign count_register = count_reg;
    assign timer_overflow_flag = flag_reg;
    assign timer_irq = irq_reg;
    assign instr_cycle_strobe = strobe_reg;
    assign watchdog_scaled_tick = wdog_tick_reg;
endmodule

// ===== tb/ptc_timer_props.sv
// Port checks for the timer/counter
`timescale 1ns/10ps
module ptc_timer_props
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic sleep,
    input wire logic count_wr,
    input wire ptc_pkg::ptc_count_t count_wdata,
    input wire logic timer_overflow_enable,
    input wire logic flag_clear,
    input wire logic [7:0] count_register,
    input wire logic timer_overflow_flag,
    input wire logic timer_irq,
    input wire logic instr_cycle_strobe
);
    import ptc_pkg::*;
    logic [3:0] hold_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Cycles left in write hold-off
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            hold_reg <= 4'h0;
        else if (count_wr)
            hold_reg <= WR_HOLD_CLKS;
        else if (hold_reg != 4'h0)
            hold_reg <= hold_reg - 4'h1;
    end
    sequence s_wrap;
        $rose(timer_overflow_flag) && !count_wr ##1 !count_wr [*2];
    endsequence
    property p_load; count_wr |=> count_register == $past(count_wdata); endproperty
    property p_hold; hold_reg > 4'h1 && !count_wr |=> $stable(count_register); endproperty
    property p_roll; s_wrap |=> count_register == 8'h00; endproperty
    property p_flag_first;
        count_register == 8'h00 && $past(count_register) == 8'hFF && !$past(count_wr)
            |-> $past(timer_overflow_flag, 3);
    endproperty
    property p_step;
        !$past(count_wr) && count_register != $past(count_register)
            |-> count_register == $past(count_register) + 8'h01;
    endproperty
    property p_irq_on; timer_overflow_flag && timer_overflow_enable |=> timer_irq; endproperty
    property p_irq_cause;
        timer_irq |-> $past(timer_overflow_flag) && $past(timer_overflow_enable);
    endproperty
    property p_sticky; timer_overflow_flag && !flag_clear |=> timer_overflow_flag; endproperty
    property p_sleep;
        sleep && $past(sleep) && !count_wr && count_register != 8'hFF
            |=> $stable(count_register);
    endproperty
    property p_strobe; instr_cycle_strobe |=> !instr_cycle_strobe [*3]; endproperty
    a_load: assert property (p_load) else $error("write not loaded");
    a_hold: assert property (p_hold) else $error("count moved in hold-off");
    a_roll: assert property (p_roll) else $error("late roll to zero");
    a_flag_first: assert property (p_flag_first) else $error("flag not ahead of wrap");
    a_step: assert property (p_step) else $error("count jumped");
    a_irq_on: assert property (p_irq_on) else $error("request missing");
    a_irq_cause: assert property (p_irq_cause) else $error("request unmasked");
    a_sticky: assert property (p_sticky) else $error("flag dropped by itself");
    a_sleep: assert property (p_sleep) else $error("count moved in sleep");
    a_strobe: assert property (p_strobe) else $error("cycle strobe too often");
endmodule
bind ptc_timer ptc_timer_props u_props
(
    .clk, .nrst, .sleep, .count_wr, .count_wdata, .timer_overflow_enable, .flag_clear,
    .count_register, .timer_overflow_flag, .timer_irq, .instr_cycle_strobe
);

// ===== tb/ptc_pin_source.sv
// External count source on the timer's pin
`timescale 1ns/10ps
module ptc_pin_source
(
    input wire logic clk,
    output logic pin
);
    initial pin = 1'h0;
    task automatic level(input logic v);
        pin = v;
    endtask
    task automatic pulses(input int n, input int hi, input int lo);
        repeat (n)
        begin
            pin = 1'h1;
            repeat (hi) @(negedge clk);
            pin = 1'h0;
            repeat (lo) @(negedge clk);
        end
    endtask
endmodule

// ===== tb/ptc_timer_bench.sv
// Self-checking bench for the timer/counter
`timescale 1ns/10ps
module ptc_timer_bench;
    import ptc_pkg::*;
    logic clk, nrst, sleep, clock_source_select, count_edge_select, prescaler_assign;
    logic external_count_pin, count_wr, timer_overflow_enable, flag_clear, watchdog_tick;
    logic watchdog_clear_instruction, timer_overflow_flag, timer_irq, instr_cycle_strobe;
    logic watchdog_scaled_tick, wprev;
    logic [7:0] count_register;
    ptc_ratio_t prescale_ratio_field;
    ptc_count_t count_wdata;
    logic [15:0] gap, n_edge;
    int fails = 0, checks_done = 0, cyc = 0;
    ptc_timer DUT (.clk, .nrst, .sleep, .clock_source_select, .count_edge_select,
        .prescaler_assign, .prescale_ratio_field, .external_count_pin, .count_wr,
        .count_wdata, .timer_overflow_enable, .flag_clear, .watchdog_clear_instruction,
        .watchdog_tick, .count_register, .timer_overflow_flag, .timer_irq,
        .instr_cycle_strobe, .watchdog_scaled_tick);
    ptc_pin_source src (.clk, .pin(external_count_pin));
    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 16'h3A98)
        begin
            fails++;
            end_of_test();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %0t ns: got %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input ptc_count_t v);
        count_wr = 1'h1;
        count_wdata = v;
        tick(1);
        count_wr = 1'h0;
    endtask
    task automatic wait_chg();
        logic [7:0] c;
        c = count_register;
        gap = 16'h0000;
        while (count_register === c && gap < 16'h0BB8)
        begin
            tick(1);
            gap++;
        end
    endtask
    task automatic wdog(input logic [15:0] exp);
        n_edge = 16'h0000;
        wprev = watchdog_scaled_tick;
        watchdog_clear_instruction = 1'h1;
        tick(1);
        watchdog_clear_instruction = 1'h0;
        for (int i = 0; i < 40; i++)
        begin
            watchdog_tick = (i < 32) && (i % 4 < 2);
            tick(1);
            if (watchdog_scaled_tick && !wprev) n_edge++;
            wprev = watchdog_scaled_tick;
        end
        check(n_edge, exp);
    endtask
    task automatic to_wdog();
        wr(8'h00);
        watchdog_clear_instruction = 1'h1;
        tick(1);
        watchdog_clear_instruction = 1'h0;
        prescaler_assign = 1'h1;
    endtask
    task automatic to_timer(input ptc_ratio_t r);
        watchdog_clear_instruction = 1'h1;
        tick(1);
        watchdog_clear_instruction = 1'h0;
        prescaler_assign = 1'h0;
        prescale_ratio_field = r;
    endtask
    //**********
    // Sequence
    //**********
    initial
    begin
        {nrst, sleep, clock_source_select, count_edge_select, count_wr, flag_clear} = '0;
        {timer_overflow_enable, watchdog_clear_instruction, watchdog_tick} = '0;
        prescaler_assign = 1'h1;
        prescale_ratio_field = 3'h0;
        count_wdata = 8'h00;
        tick(5);
        nrst = 1'h1;
        check({count_register, timer_overflow_flag, timer_irq}, 16'h0000);
        wr(8'h10);
        check(count_register, 8'h10);
        tick(7);
        check(count_register, 8'h10);
        wait_chg();
        wait_chg();
        check(gap, 16'h0004);
        to_timer(3'h0);
        for (int n = 0; n < 8; n++)
        begin
            prescale_ratio_field = 3'(n);
            wr(8'h00);
            wait_chg();
            wait_chg();
            check(gap, 16'(4 << (n + 1)));
        end
        tick(600);
        wr(8'h00);
        wait_chg();
        check(gap >= 16'h01FC && gap <= 16'h0210, 1'h1);
        to_wdog();
        wr(8'hFE);
        tick(30);
        check({timer_overflow_flag, timer_irq}, 2'h2);
        check(count_register < 8'h05, 1'h1);
        timer_overflow_enable = 1'h1;
        tick(2);
        check(timer_irq, 1'h1);
        tick(20);
        check(timer_overflow_flag, 1'h1);
        flag_clear = 1'h1;
        tick(1);
        flag_clear = 1'h0;
        tick(2);
        check({timer_overflow_flag, timer_irq}, 2'h0);
        timer_overflow_enable = 1'h0;
        clock_source_select = 1'h1;
        for (int e = 0; e < 2; e++)
        begin
            count_edge_select = 1'(e);
            tick(10);
            wr(8'h00);
            tick(10);
            src.level(1'h1);
            tick(12);
            check(count_register, 8'(1 - e));
            src.level(1'h0);
            tick(12);
            check(count_register, 8'h01);
        end
        wr(8'h00);
        tick(10);
        src.pulses(10, 2, 2);
        tick(12);
        check(count_register, 8'h0A);
        to_timer(3'h0);
        tick(10);
        wr(8'h00);
        tick(10);
        src.pulses(20, 2, 2);
        tick(16);
        check(count_register, 8'h0A);
        clock_source_select = 1'h0;
        to_wdog();
        wr(8'h05);
        sleep = 1'h1;
        tick(40);
        check({count_register, instr_cycle_strobe}, 9'h00A);
        sleep = 1'h0;
        tick(20);
        check(count_register > 8'h05, 1'h1);
        wdog(16'h0004);
        to_timer(3'h0);
        wdog(16'h0008);
        end_of_test();
    end
endmodule
